// *** rtl/serial_device_end.sv ***
/*
  device end of the four-wire serial port: samples the link pins,
  decodes command bytes and moves data to and from a 16-entry
  register space on the user side, and holds the seconds carry.
  assumes the user side answers reads from rd_data in the cycle after
  rd_req and that the link runs far below clk.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_device_end (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // link
  serial_link_if.device   link,
  // register access
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output logic [3:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            rd_req,
  output logic [3:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  // carry control
  output logic            carry_hold,
  output logic            session_active
);
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_cmd  = 2'b01,
    st_data = 2'b11
  } phase_type;

  typedef struct packed {
    logic [1:0] sel_sync;
    logic [1:0] sclk_sync;
    logic [1:0] sin_sync;
    logic       sel_d;
    logic       sclk_d;
    logic       in_on_rise;
    phase_type  phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [3:0] addr;
    logic [3:0] fmt;
    logic       rd_pend;
    logic       load_out;
    logic       sout_o;
    logic       sout_oe;
    logic [1:0] buf_cnt;
    logic [11:0] buf_word0;
    logic [11:0] buf_word1;
    logic [24:0] hold_cnt;
    logic        hold_over;
  } state_type;

  state_type s;
  state_type next_s;

  // last count of a one-second select-high period
  localparam logic [24:0] hold_last = 25'(serial_port_pkg::hold_limit_cyc - 1);

  // format decode, used by the command and data paths
  function automatic logic is_read(input logic [3:0] f);
    is_read = (f == serial_port_pkg::fmt_read_single) || (f == serial_port_pkg::fmt_read_burst);
  endfunction

  function automatic logic is_burst(input logic [3:0] f);
    is_burst = (f == serial_port_pkg::fmt_read_burst) || (f == serial_port_pkg::fmt_write_burst);
  endfunction

  logic sel;
  logic sclk;
  logic sin;
  logic rise;
  logic fall;
  logic sample_edge;
  logic shift_edge;
  logic [7:0] byte_now;

  // synchronised pins and edges
  assign sel         = s.sel_sync[1];
  assign sclk        = s.sclk_sync[1];
  assign sin         = s.sin_sync[1];
  assign rise        = sclk & ~s.sclk_d;
  assign fall        = ~sclk & s.sclk_d;
  assign sample_edge = s.in_on_rise ? rise : fall;
  assign shift_edge  = s.in_on_rise ? fall : rise;
  assign byte_now    = {s.shift_in[6:0], sin};

  // outputs
  assign link.sout_o    = s.sout_o;
  assign link.sout_oe   = s.sout_oe;
  assign wr_valid       = s.buf_cnt != 2'd0;
  assign wr_addr        = s.buf_word0[11:8];
  assign wr_data        = s.buf_word0[7:0];
  assign rd_req         = s.rd_pend;
  assign rd_addr        = s.addr;
  assign carry_hold     = sel & ~s.hold_over;
  assign session_active = s.phase != st_idle;

  // next state
  always_comb begin
    next_s           = s;
    next_s.sel_sync  = {s.sel_sync[0], link.select};
    next_s.sclk_sync = {s.sclk_sync[0], link.sclk};
    next_s.sin_sync  = {s.sin_sync[0], link.sin};
    next_s.sel_d     = sel;
    next_s.sclk_d    = sclk;
    next_s.rd_pend   = 1'b0;
    next_s.load_out  = s.rd_pend;
    // drain buffer
    // word0 leaves, word1 moves up
    if (wr_valid && wr_ready) begin
      next_s.buf_word0 = s.buf_word1;
      next_s.buf_cnt   = s.buf_cnt - 2'd1;
    end
    if (s.load_out) begin
      next_s.shift_out = rd_data;
    end
    // held carry is let go after one second of select high
    if (!sel) begin
      next_s.hold_cnt  = 25'd0;
      next_s.hold_over = 1'b0;
    end else if (s.hold_cnt == hold_last) begin
      next_s.hold_over = 1'b1;
    end else begin
      next_s.hold_cnt = s.hold_cnt + 25'd1;
    end
    if (sel && !s.sel_d) begin
      next_s.in_on_rise = sclk;
      next_s.phase      = st_cmd;
      next_s.bit_cnt    = 3'd0;
    end else if (!sel) begin
      next_s.phase   = st_idle;
      next_s.bit_cnt = 3'd0;
      next_s.sout_oe = 1'b0;
    end else if (sample_edge) begin
      next_s.shift_in = byte_now;
      next_s.bit_cnt  = s.bit_cnt + 3'd1;
      if (s.bit_cnt == 3'd7) begin
        if (s.phase == st_cmd) begin
          next_s.addr  = byte_now[serial_port_pkg::addr_msb:serial_port_pkg::addr_lsb];
          next_s.fmt   = byte_now[serial_port_pkg::fmt_msb:serial_port_pkg::fmt_lsb];
          next_s.phase = st_data;
          next_s.rd_pend = is_read(byte_now[3:0]);
        end else begin
          if (!is_read(s.fmt)) begin
            // buffer holds the word if user stalls
            // a full buffer keeps its words and drops the new one
            if (next_s.buf_cnt == 2'd0) begin
              next_s.buf_word0 = {s.addr, byte_now};
            end else if (next_s.buf_cnt == 2'd1) begin
              next_s.buf_word1 = {s.addr, byte_now};
            end
            if (next_s.buf_cnt != 2'd2) begin
              next_s.buf_cnt = next_s.buf_cnt + 2'd1;
            end
          end
          if (is_burst(s.fmt)) begin
            next_s.addr    = s.addr + 4'h1;
            next_s.rd_pend = is_read(s.fmt);
          end else begin
            next_s.phase = st_cmd;
          end
        end
      end
    end else if (shift_edge && s.phase == st_data && is_read(s.fmt)) begin
      next_s.sout_oe   = 1'b1;
      next_s.sout_o    = s.shift_out[7];
      next_s.shift_out = {s.shift_out[6:0], 1'b0};
    end else if (shift_edge && s.phase == st_cmd) begin
      next_s.sout_oe = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// *** rtl/serial_host_end.sv ***
/*
  host end of the four-wire serial port: frames one command and its
  data bytes per request, makes the serial clock by dividing clk, and
  keeps select timing.
  assumes the device end samples pins with two flip-flops.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_host_end #(
  parameter int unsigned half_cyc = serial_port_pkg::sclk_half_cyc
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // link
  serial_link_if.host     link,
  // request
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic [3:0] req_addr,
  input  wire logic [3:0] req_fmt,
  input  wire logic [7:0] req_wdata,
  input  wire logic [4:0] req_count,
  // read data
  output logic            rsp_valid,
  output logic [7:0]      rsp_data
);
  // sout needs five clocks from a rising edge to reach sout_sync[1]
  if (half_cyc < 5 || half_cyc > 65535) begin : g_half_cyc_check
    $error("half_cyc out of range");
  end

  typedef enum logic [2:0] {
    hs_idle  = 3'b000,
    hs_setup = 3'b001,
    hs_shift = 3'b011,
    hs_tail  = 3'b010,
    hs_gap   = 3'b110
  } hstate_type;

  typedef struct packed {
    hstate_type st;
    logic       select;
    logic       sclk;
    logic       sin;
    logic [15:0] tmr;
    logic [2:0]  bit_cnt;
    logic [4:0]  bytes_left;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [7:0]  wdata;
    logic        rd;
    logic        first;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
  } hst_type;

  hst_type h;
  hst_type next_h;
  logic [1:0] sout_sync;

  assign link.select = h.select;
  assign link.sclk   = h.sclk;
  assign link.sin    = h.sin;
  assign req_ready   = h.st == hs_idle;
  assign rsp_valid   = h.rsp_valid;
  assign rsp_data    = h.rsp_data;

  // sclk idles low: both ends change on rise and sample on fall
  always_comb begin
    next_h           = h;
    next_h.rsp_valid = 1'b0;
    unique case (h.st)
      hs_idle: begin
        if (req_valid) begin
          next_h.select     = 1'b1;
          next_h.tx         = {req_addr, req_fmt};
          next_h.wdata      = req_wdata;
          next_h.rd         = req_fmt[2];
          next_h.bytes_left = req_count;
          next_h.first      = 1'b1;
          next_h.bit_cnt    = 3'd0;
          next_h.tmr        = 16'(serial_port_pkg::carry_settle_cyc);
          next_h.st         = hs_setup;
        end
      end
      hs_setup: begin
        next_h.tmr = h.tmr - 16'd1;
        if (h.tmr == 16'd0) begin
          next_h.sin = h.tx[7];
          next_h.tmr = 16'(half_cyc);
          next_h.st  = hs_shift;
        end
      end
      hs_shift: begin
        next_h.tmr = h.tmr - 16'd1;
        if (h.tmr == 16'd0) begin
          next_h.tmr  = 16'(half_cyc);
          next_h.sclk = ~h.sclk;
          if (!h.sclk) begin
            // rising edge: present the next bit, msb first
            next_h.sin = h.tx[7];
            next_h.tx  = {h.tx[6:0], 1'b0};
          end else begin
            // falling edge: device samples sin, host samples sout
            next_h.bit_cnt = h.bit_cnt + 3'd1;
            next_h.rx      = {h.rx[6:0], sout_sync[1]};
            if (h.bit_cnt == 3'd7) begin
              if (!h.first && h.rd) begin
                next_h.rsp_valid = 1'b1;
                next_h.rsp_data  = {h.rx[6:0], sout_sync[1]};
              end
              if (!h.first) begin
                next_h.bytes_left = h.bytes_left - 5'd1;
              end
              next_h.first = 1'b0;
              next_h.tx    = h.wdata;
              if (!h.first && h.bytes_left == 5'd1) begin
                next_h.st = hs_tail;
              end
            end
          end
        end
      end
      // select stays high until the device has taken the last bit
      hs_tail: begin
        next_h.tmr = h.tmr - 16'd1;
        if (h.tmr == 16'd0) begin
          next_h.select = 1'b0;
          next_h.sin    = 1'b0;
          next_h.tmr    = 16'(serial_port_pkg::select_gap_cyc);
          next_h.st     = hs_gap;
        end
      end
      hs_gap: begin
        next_h.tmr = h.tmr - 16'd1;
        if (h.tmr == 16'd0) begin
          next_h.st = hs_idle;
        end
      end
      default: next_h.st = hs_idle;
    endcase
  end

  // state register and sout synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      h         <= '0;
      sout_sync <= 2'b00;
    end else begin
      h         <= next_h;
      sout_sync <= {sout_sync[0], link.sout};
    end
  end
endmodule
`default_nettype wire

// *** rtl/serial_link_if.sv ***
/*
  four-wire link between host and device ends.
  assumes both ends share clk and rst_n; serial out is tri-state.
*/
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
  logic select;     // host_select_line
  logic sclk;       // serial_clock_line
  logic sin;        // serial_in_line, host to device
  logic sout_o;     // serial_out_line value from device
  logic sout_oe;    // device drives serial_out_line
  logic sout;       // resolved level seen by host

  // pull-down stands in for the undriven line
  assign sout = sout_oe ? sout_o : 1'b0;

  modport device (input select, input sclk, input sin, output sout_o, output sout_oe);
  modport host   (output select, output sclk, output sin, input sout);
endinterface
`default_nettype wire

// *** rtl/serial_port_pkg.sv ***
/*
  constants shared by both ends of the four-wire serial port link:
  command byte layout, transfer format codes and timing counts.
  assumes a 20 MHz system clock on both ends.
*/
package serial_port_pkg;
  localparam int unsigned clk_mhz          = 20;
  localparam int unsigned byte_bits        = 8;
  localparam int unsigned addr_msb         = 7;
  localparam int unsigned addr_lsb         = 4;
  localparam int unsigned fmt_msb          = 3;
  localparam int unsigned fmt_lsb          = 0;
  localparam logic [3:0]  fmt_write_single = 4'h8;
  localparam logic [3:0]  fmt_write_burst  = 4'h0;
  localparam logic [3:0]  fmt_read_single  = 4'hc;
  localparam logic [3:0]  fmt_read_burst   = 4'h4;
  localparam logic [3:0]  addr_last        = 4'hf;
  localparam logic [3:0]  addr_first       = 4'h0;
  localparam logic [3:0]  time_addr_last   = 4'h6;
  // host timing, microseconds as printed
  localparam int unsigned carry_settle_us  = 31;
  localparam int unsigned select_gap_us    = 62;
  localparam int unsigned carry_settle_cyc = carry_settle_us * clk_mhz;
  localparam int unsigned select_gap_cyc   = select_gap_us * clk_mhz;
  // longest select-high period allowed, one second
  localparam int unsigned hold_limit_cyc   = 1000000 * clk_mhz;
  // serial clock half period in clocks, less one
  localparam int unsigned sclk_half_cyc    = 5;
endpackage

// *** verif/rtc_four_wire_serial_port_tb.sv ***
/*
  testbench: host end and device end joined by the link interface.
  assumes the user side of the device answers reads one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_four_wire_serial_port_tb;
  logic        clk;
  logic        rst_n;
  logic        wr_ready;
  logic        req_valid;
  logic [3:0]  req_addr;
  logic [3:0]  req_fmt;
  logic [7:0]  req_wdata;
  logic [4:0]  req_count;
  logic [7:0]  rd_data;
  logic        wr_valid;
  logic        rd_req;
  logic        carry_hold;
  logic        session_active;
  logic        req_ready;
  logic        rsp_valid;
  logic [3:0]  wr_addr;
  logic [3:0]  rd_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rsp_data;
  int          error_cnt;
  int          total_checks;
  logic [11:0] wq[$];
  logic [7:0]  rq[$];

  serial_link_if link();
  serial_host_end u_serial_host_end (.clk(clk), .rst_n(rst_n), .link(link),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr), .req_fmt(req_fmt),
    .req_wdata(req_wdata), .req_count(req_count), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  serial_device_end u_serial_device_end (.clk(clk), .rst_n(rst_n), .link(link),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .carry_hold(carry_hold),
    .session_active(session_active));
  serial_link_monitor u_serial_link_monitor (.clk(clk), .rst_n(rst_n),
    .select(link.select), .sclk(link.sclk), .sin(link.sin), .sout_o(link.sout_o),
    .sout_oe(link.sout_oe), .sout(link.sout));

  // clock and register space answer
  initial clk = 1'b0;
  always #25 clk = ~clk;
  always @(negedge clk) rd_data <= {~rd_addr, rd_addr};

  // collect accepted writes and returned read bytes
  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back({wr_addr, wr_data});
    if (rsp_valid === 1'b1) rq.push_back(rsp_data);
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick(inout int i, input int lim);
    @(negedge clk);
    i++;
    if (i > lim) begin
      error_cnt++;
      $display("mismatch wait expected done seen timeout");
      complete_run();
    end
  endtask

  // one host request, waits until the host is idle again
  task automatic send(input logic [3:0] a, input logic [3:0] f, input logic [7:0] d,
                      input logic [4:0] n);
    int i;
    i = 0;
    @(negedge clk);
    {req_addr, req_fmt, req_wdata, req_count, req_valid} = {a, f, d, n, 1'b1};
    while (req_ready !== 1'b1) tick(i, 5000);
    @(negedge clk);
    req_valid = 1'b0;
    repeat (20) @(negedge clk);
    chk("carry_hold high", 12'h001, {11'h000, carry_hold});
    chk("session_active high", 12'h001, {11'h000, session_active});
    i = 0;
    while (req_ready !== 1'b1) tick(i, 30000);
    chk("carry_hold low", 12'h000, {11'h000, carry_hold});
    chk("session_active low", 12'h000, {11'h000, session_active});
  endtask

  task automatic t_write_single;
    wq.delete();
    send(4'h7, serial_port_pkg::fmt_write_single, 8'ha5, 5'd1);
    chk("write count", 12'd1, 12'(wq.size()));
    chk("write", {4'h7, 8'ha5}, wq[0]);
    $display("test write_single done");
  endtask

  task automatic t_write_burst;
    wq.delete();
    @(negedge clk);
    wr_ready = 1'b0;
    fork
      send(4'he, serial_port_pkg::fmt_write_burst, 8'h5a, 5'd3);
      begin
        repeat (960) @(negedge clk);
        chk("stall accepts", 12'd0, 12'(wq.size()));
        chk("stall holds word", 12'h001, {11'h000, wr_valid});
        wr_ready = 1'b1;
      end
    join
    chk("burst count", 12'd3, 12'(wq.size()));
    for (int i = 0; i < 3; i++) chk("burst write", {4'he + 4'(i), 8'h5a}, wq[i]);
    $display("test write_burst done");
  endtask

  task automatic t_read(input logic [3:0] a, input logic [3:0] f, input int n);
    logic [3:0] x;
    wq.delete();
    rq.delete();
    send(a, f, 8'h00, 5'(n));
    chk("read count", 12'(n), 12'(rq.size()));
    chk("read writes", 12'd0, 12'(wq.size()));
    for (int i = 0; i < n; i++) begin
      x = a + 4'(i);
      chk("read data", {4'h0, ~x, x}, {4'h0, rq[i]});
    end
    $display("test read fmt %h done", f);
  endtask

  initial begin
    {rst_n, wr_ready, req_valid, req_addr, req_fmt} = {1'b0, 1'b1, 1'b0, 8'h00};
    {req_wdata, req_count} = 13'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_write_single();
    t_write_burst();
    t_read(4'h2, serial_port_pkg::fmt_read_single, 1);
    t_read(4'hf, serial_port_pkg::fmt_read_burst, 3);
    complete_run();
  end
endmodule
`default_nettype wire

// *** verif/serial_link_monitor.sv ***
/*
  checker for the four-wire link between host and device ends.
  assumes one clock domain; instantiated beside the link interface.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_link_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link signals
  input wire logic select,
  input wire logic sclk,
  input wire logic sin,
  input wire logic sout_o,
  input wire logic sout_oe,
  input wire logic sout
);
  logic [10:0] gap_cnt;
  logic [9:0]  hi_cnt;
  logic [2:0]  bit_cnt;
  logic        sclk_q;

  // cycles of select low, cycles of select high, bits in a session
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= 11'h7ff;
      hi_cnt  <= 10'h000;
      bit_cnt <= 3'h0;
      sclk_q  <= 1'b0;
    end else begin
      sclk_q  <= sclk;
      gap_cnt <= select ? 11'h000 : ((gap_cnt == 11'h7ff) ? gap_cnt : gap_cnt + 11'h001);
      hi_cnt  <= !select ? 10'h000 : ((hi_cnt == 10'h3ff) ? hi_cnt : hi_cnt + 10'h001);
      bit_cnt <= !select ? 3'h0 : ((sclk && !sclk_q) ? bit_cnt + 3'h1 : bit_cnt);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // select low long enough for the device to see it
  sequence idle_s;
    !select [*6];
  endsequence
  // one serial clock high phase, six cycles wide
  sequence sclk_high_s;
    sclk [*6] ##1 !sclk;
  endsequence

  sclk_rest_a: assert property (!select |-> !sclk)
    else $error("serial clock moves outside a session");
  mode_low_a: assert property ($rose(select) |-> !sclk)
    else $error("serial clock high when select rises");
  sclk_width_a: assert property ($rose(sclk) |-> sclk_high_s)
    else $error("serial clock high phase width wrong");
  sin_edge_a: assert property (select && $fell(sclk) |-> $stable(sin))
    else $error("serial input moves at the sampling edge");
  whole_bytes_a: assert property ($fell(select) |-> bit_cnt == 3'h0)
    else $error("session ends on a partial byte");
  select_gap_a: assert property ($rose(select) |-> gap_cnt >= 11'd1240)
    else $error("select low gap too short");
  settle_wait_a: assert property (select && $rose(sclk) |-> hi_cnt >= 10'd620)
    else $error("first serial clock too soon after select");
  out_idle_a: assert property (idle_s |-> !sout_oe)
    else $error("serial output driven with select low");
  out_steady_a: assert property (select && $fell(sclk) |-> $stable(sout) && $stable(sout_o))
    else $error("serial output moves at the sampling edge");
endmodule
`default_nettype wire
